/* include/dcr_pkg.sv */
package dcr_pkg;

  localparam int          DCR_NUM_CH    = 6;
  localparam int          DCR_CTX_WORDS = 3;
  localparam int          DCR_CNT_WORD  = 2;

  localparam int          CH_SEL_LSB    = 5;
  localparam int          CH_SEL_W      = 3;
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_CFG       = 5'h04;
  localparam logic [4:0]  OFS_WORK      = 5'h10;

  localparam int          BIT_DONE      = 11;
  localparam int          BIT_RSVD      = 10;
  localparam int          BIT_REPEAT    = 9;
  localparam int          BIT_AUTO      = 8;
  localparam int          BIT_EN        = 7;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK    = 16'hfbff;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  typedef enum logic [2:0] {
    DCR_IDLE,
    DCR_LOAD,
    DCR_RUN,
    DCR_WAIT,
    DCR_RELOAD
  } dcr_state_type;

endpackage

/* src/dcr_ctx_bank.sv */
module dcr_ctx_bank #(
  parameter int WORDS = 3,
  parameter int IW    = 2
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  cfg_we,
  input  wire logic [IW-1:0]         cfg_sel,
  input  wire logic [31:0]           cfg_wdata,
  input  wire logic                  copy,
  output logic      [WORDS*32-1:0]   cfg_q,
  output logic      [WORDS*32-1:0]   work_q
);
  import dcr_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][31:0] cfg;
    logic [WORDS-1:0][31:0] work;
  } dcr_bank_type;

  dcr_bank_type bank_r;
  dcr_bank_type bank_nxt;

  always_comb begin
    bank_nxt = bank_r;
    // Copy takes the configuration as it stood before this edge
    if (copy) begin
      bank_nxt.work = bank_r.cfg;
    end
    if (cfg_we) begin
      bank_nxt.cfg[cfg_sel] = cfg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int w = 0; w < WORDS; w++) begin
        bank_r.cfg[w]  <= WORD_RESET;
        bank_r.work[w] <= WORD_RESET;
      end
    end else begin
      bank_r <= bank_nxt;
    end
  end

  assign cfg_q  = bank_r.cfg;
  assign work_q = bank_r.work;

endmodule

/* src/dcr_reload.sv */
module dcr_reload #(
  parameter int NUM_CH    = dcr_pkg::DCR_NUM_CH,
  parameter int CTX_WORDS = dcr_pkg::DCR_CTX_WORDS
) (
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [NUM_CH-1:0]            elem_step,
  output logic      [NUM_CH-1:0]            ch_busy,
  output logic      [NUM_CH-1:0]            ch_reload,
  output logic      [NUM_CH*CTX_WORDS*32-1:0] work_ctx
);
  import dcr_pkg::*;

  localparam int IW = (CTX_WORDS > 1) ? $clog2(CTX_WORDS) : 1;

  typedef struct packed {
    dcr_state_type st;
    logic [15:0]   ctrl;
    logic [31:0]   remain;
    logic          busy;
    logic          reload;
  } dcr_chan_type;

  typedef struct packed {
    dcr_chan_type [NUM_CH-1:0] ch;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } dcr_top_type;

  dcr_top_type top_r;
  dcr_top_type top_nxt;

  logic [CTX_WORDS*32-1:0] cfg_q  [NUM_CH];
  logic [CTX_WORDS*32-1:0] work_q [NUM_CH];
  logic [NUM_CH-1:0]       cfg_we;
  logic [NUM_CH-1:0]       copy;
  logic [IW-1:0]           cfg_sel;

  // Address decode
  logic [CH_SEL_W-1:0] sel_ch;
  logic [4:0]          ofs;
  logic [4:0]          cfg_d;
  logic [4:0]          work_d;
  logic                ch_ok;
  logic                hit_ctrl;
  logic                hit_cfg;
  logic                hit_work;
  logic                commit_wr;

  assign sel_ch    = paddr[CH_SEL_LSB +: CH_SEL_W];
  assign ofs       = paddr[4:0];
  assign cfg_d     = ofs - OFS_CFG;
  assign work_d    = ofs - OFS_WORK;
  assign ch_ok     = (paddr[31:8] == 24'h00_0000) && (32'(sel_ch) < NUM_CH);
  assign hit_ctrl  = ch_ok && (ofs == OFS_CTRL);
  assign hit_cfg   = ch_ok && (ofs >= OFS_CFG) && (ofs[1:0] == 2'h0)
                     && (32'(cfg_d[4:2]) < CTX_WORDS);
  assign hit_work  = ch_ok && (ofs >= OFS_WORK) && (ofs[1:0] == 2'h0)
                     && (32'(work_d[4:2]) < CTX_WORDS);
  assign commit_wr = psel && penable && top_r.pready && pwrite;
  assign cfg_sel   = cfg_d[IW+1:2];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign cfg_we[gi] = commit_wr && hit_cfg && (32'(sel_ch) == gi);
      assign copy[gi]   = (top_r.ch[gi].st == DCR_LOAD) || (top_r.ch[gi].st == DCR_RELOAD);
      dcr_ctx_bank #(
        .WORDS (CTX_WORDS),
        .IW    (IW)
      ) u_bank (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .cfg_we    (cfg_we[gi]),
        .cfg_sel   (cfg_sel),
        .cfg_wdata (pwdata),
        .copy      (copy[gi]),
        .cfg_q     (cfg_q[gi]),
        .work_q    (work_q[gi])
      );
      assign work_ctx[gi*CTX_WORDS*32 +: CTX_WORDS*32] = work_q[gi];
      assign ch_busy[gi]   = top_r.ch[gi].busy;
      assign ch_reload[gi] = top_r.ch[gi].reload;
    end
  endgenerate

  always_comb begin
    logic [31:0]  rd;
    logic         sw_ctrl;
    logic         blk_end;
    dcr_chan_type c;
    rd      = 32'h0000_0000;
    sw_ctrl = 1'b0;
    blk_end = 1'b0;
    c       = top_r.ch[0];
    top_nxt = top_r;

    // One wait state: answer registered in the first access cycle
    top_nxt.pready  = 1'b0;
    // Error flag only shown alongside an answer
    top_nxt.pslverr = 1'b0;
    if (psel && penable && !top_r.pready) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (32'(sel_ch) == i) begin
          if (hit_ctrl) begin
            rd = {16'h0000, top_r.ch[i].ctrl};
          end else if (hit_cfg) begin
            rd = cfg_q[i][32*cfg_sel +: 32];
          end else if (hit_work) begin
            rd = work_q[i][32*work_d[IW+1:2] +: 32];
          end
        end
      end
      top_nxt.pready  = 1'b1;
      top_nxt.prdata  = rd;
      top_nxt.pslverr = !(hit_ctrl || hit_cfg || (hit_work && !pwrite));
    end

    for (int i = 0; i < NUM_CH; i++) begin
      c       = top_r.ch[i];
      sw_ctrl = commit_wr && hit_ctrl && (32'(sel_ch) == i);
      blk_end = (c.st == DCR_RUN)
                && ((c.remain == 32'h0000_0000)
                    || (elem_step[i] && (c.remain == 32'h0000_0001)));
      c.reload = 1'b0;
      if (sw_ctrl) begin
        // Reserved bit never stored, reads back as 0
        c.ctrl = pwdata[15:0] & CTRL_WMASK;
      end
      if ((top_r.ch[i].st == DCR_RUN) && elem_step[i] && (c.remain != 32'h0000_0000)) begin
        c.remain = c.remain - 32'h0000_0001;
      end
      unique case (top_r.ch[i].st)
        DCR_IDLE: begin
          if (c.ctrl[BIT_EN]) begin
            c.st = DCR_LOAD;
          end
        end
        DCR_LOAD: begin
          c.remain = cfg_q[i][32*DCR_CNT_WORD +: 32];
          c.st     = c.ctrl[BIT_EN] ? DCR_RUN : DCR_IDLE;
        end
        DCR_RUN: begin
          if (!c.ctrl[BIT_EN]) begin
            c.st = DCR_IDLE;
          end else if (blk_end) begin
            if (!c.ctrl[BIT_AUTO]) begin
              c.ctrl[BIT_EN] = 1'b0;
              c.st           = DCR_IDLE;
            end else if (c.ctrl[BIT_REPEAT] || top_r.ch[i].ctrl[BIT_DONE]) begin
              c.st = DCR_RELOAD;
            end else begin
              c.st = DCR_WAIT;
            end
          end
        end
        DCR_WAIT: begin
          if (!c.ctrl[BIT_EN]) begin
            c.st = DCR_IDLE;
          end else if (!c.ctrl[BIT_AUTO]) begin
            c.ctrl[BIT_EN] = 1'b0;
            c.st           = DCR_IDLE;
          end else if (c.ctrl[BIT_REPEAT] || top_r.ch[i].ctrl[BIT_DONE]) begin
            c.st = DCR_RELOAD;
          end
        end
        DCR_RELOAD: begin
          c.remain = cfg_q[i][32*DCR_CNT_WORD +: 32];
          c.reload = 1'b1;
          // A flag set written in the copy cycle survives
          if (!(sw_ctrl && pwdata[BIT_DONE])) begin
            c.ctrl[BIT_DONE] = 1'b0;
          end
          c.st = c.ctrl[BIT_EN] ? DCR_RUN : DCR_IDLE;
        end
      endcase
      c.busy        = (c.st != DCR_IDLE);
      top_nxt.ch[i] = c;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        top_r.ch[i].st     <= DCR_IDLE;
        top_r.ch[i].ctrl   <= CTRL_RESET;
        top_r.ch[i].remain <= WORD_RESET;
        top_r.ch[i].busy   <= 1'b0;
        top_r.ch[i].reload <= 1'b0;
      end
      top_r.pready  <= 1'b0;
      top_r.pslverr <= 1'b0;
      top_r.prdata  <= WORD_RESET;
    end else begin
      top_r <= top_nxt;
    end
  end

  assign prdata  = top_r.prdata;
  assign pready  = top_r.pready;
  assign pslverr = top_r.pslverr;

endmodule

/* testbench/dcr_reload_monitor.sv */
module dcr_reload_monitor #(
  parameter int NUM_CH    = 6,
  parameter int CTX_WORDS = 3
) (
  input wire logic                           ref_clk,
  input wire logic                           sys_rst,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [31:0]                    paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic [NUM_CH-1:0]              elem_step,
  input wire logic [NUM_CH-1:0]              ch_busy,
  input wire logic [NUM_CH-1:0]              ch_reload,
  input wire logic [NUM_CH*CTX_WORDS*32-1:0] work_ctx
);
  import dcr_pkg::*;
  logic map_ok;
  assign map_ok = paddr[31:8] == 24'h00_0000 && int'(paddr[7:5]) < NUM_CH;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ack_wait; psel && penable && !pready |=> pready; endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("no answer after one wait");
  property p_slverr; pslverr |-> pready; endproperty
  a_slverr: assert property (p_slverr) else $error("error flag outside answer");
  property p_ctrl_rd;
    pready && !pwrite && map_ok && paddr[4:0] == OFS_CTRL
      |-> !pslverr && !prdata[BIT_RSVD] && prdata[31:16] == 16'h0000;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("bad control read");
  property p_cfg_ok; pready && map_ok && paddr[4:0] == OFS_CFG |-> !pslverr; endproperty
  a_cfg_ok: assert property (p_cfg_ok) else $error("config access refused");
  property p_work_ro; pready && pwrite && map_ok && paddr[4:0] == OFS_WORK |-> pslverr; endproperty
  a_work_ro: assert property (p_work_ro) else $error("working write accepted");
  property p_work_busy; !$stable(work_ctx) |-> |ch_busy; endproperty
  a_work_busy: assert property (p_work_busy) else $error("working set moved while idle");
  property p_rl_pulse; ch_reload[0] |=> !ch_reload[0]; endproperty
  a_rl_pulse: assert property (p_rl_pulse) else $error("reload pulse too long");
  property p_rl_busy; (ch_reload & ~ch_busy) == '0; endproperty
  a_rl_busy: assert property (p_rl_busy) else $error("reload on idle channel");
  property p_rl_prev; ch_reload[0] |-> $past(ch_busy[0], 2); endproperty
  a_rl_prev: assert property (p_rl_prev) else $error("reload after idle");
endmodule

bind dcr_reload dcr_reload_monitor #(.NUM_CH(NUM_CH), .CTX_WORDS(CTX_WORDS)) i_dcr_reload_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .elem_step(elem_step), .ch_busy(ch_busy), .ch_reload(ch_reload), .work_ctx(work_ctx));

/* testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcr_pkg::*;
  logic         ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]  paddr = '0, pwdata = '0, prdata;
  logic         pready, pslverr;
  logic [5:0]   elem_step = '0, ch_busy, ch_reload;
  logic [575:0] work_ctx;
  logic [33:0]  exp_q[$], ae;
  logic [95:0]  rq[$], c0, c1;
  logic [15:0]  seed = 16'hddb6;
  int           err_count = 0, n_tests = 0;
  dcr_reload i_dcr_reload (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .elem_step(elem_step), .ch_busy(ch_busy),
    .ch_reload(ch_reload), .work_ctx(work_ctx));
  initial forever #50 ref_clk = ~ref_clk;
  function logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd = {seed, ~seed};
  endfunction
  task chk(input logic [95:0] g, input logic [95:0] x);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic er,
           input logic [31:0] x);
    @(posedge ref_clk);
    exp_q.push_back({!wr && !er, er, x});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ctx(input logic wr, input logic [31:0] a, input logic [95:0] c);
    for (int w = 0; w < 3; w++) apb(wr, a + 4 * w, c[32*w +: 32], 1'b0, wr ? '0 : c[32*w +: 32]);
  endtask
  task step(input int n);
    repeat (3) @(posedge ref_clk);
    repeat (n) begin
      @(posedge ref_clk);
      elem_step[0] <= 1'b1;
    end
    @(posedge ref_clk);
    elem_step[0] <= 1'b0;
  endtask
  // Answers and reload pulses are matched against the oldest note
  always @(negedge ref_clk) begin
    if (pready === 1'b1) begin
      ae = exp_q.size() ? exp_q.pop_front() : 'x;
      chk({pslverr, ae[33] ? prdata : 32'h0000_0000}, {ae[32], ae[33] ? ae[31:0] : 32'h0});
    end
    if (ch_reload[0] === 1'b1) chk(work_ctx[95:0], rq.size() ? rq.pop_front() : 'x);
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    results();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 32'h0000_0000, '0, 1'b0, 32'h0000_0000);
    c0 = {32'h0000_0002, rnd(), rnd()};
    c1 = {32'h0000_0002, rnd(), rnd()};
    ctx(1'b1, 32'h0000_0004, c0);
    ctx(1'b0, 32'h0000_0004, c0);
    apb(1'b1, 32'h0000_0000, 32'h0000_0180, 1'b0, '0);
    ctx(1'b0, 32'h0000_0010, c0);
    step(2);
    ctx(1'b1, 32'h0000_0004, c1);
    ctx(1'b0, 32'h0000_0010, c0);
    rq.push_back(c1);
    apb(1'b1, 32'h0000_0000, 32'h0000_0980, 1'b0, '0);
    apb(1'b0, 32'h0000_0000, '0, 1'b0, 32'h0000_0180);
    rq.push_back(c1);
    apb(1'b1, 32'h0000_0000, 32'h0000_0380, 1'b0, '0);
    step(2);
    apb(1'b1, 32'h0000_0000, 32'h0000_0080, 1'b0, '0);
    step(2);
    apb(1'b0, 32'h0000_0000, '0, 1'b0, 32'h0000_0000);
    chk(ch_busy, '0);
    apb(1'b0, 32'h0000_0100, '0, 1'b1, '0);
    apb(1'b1, 32'h0000_0010, 32'hffff_ffff, 1'b1, '0);
    repeat (5) @(posedge ref_clk);
    chk(exp_q.size() + rq.size(), '0);
    results();
  end
endmodule
